// File: bench/ikr_pins_model.sv
// Purpose: Far-side model of external interrupt pins and key lines
// Assumes: Keys pull lines low when pressed
// Notes: Released key lines sit at their pull-up level
`timescale 1ns/1ps
module ikr_pins_model (
  input wire logic [3:0] ext_drv,
  input wire logic [3:0] key_press,
  output logic [3:0] ext_pin,
  output logic [3:0] key_pin
);
  // External pins follow the driven level directly
  assign ext_pin = ext_drv;
  // Pressed key grounds its line, otherwise pulled high
  assign key_pin = ~key_press;
endmodule // ikr_pins_model

// File: bench/testbench.sv
// Purpose: Self-checking bench for the interrupt and key-return controller
// Assumes: One-cycle APB answer, flags settle within eight cycles
// Notes: Random rising edge enable data from a bench LFSR
`timescale 1ns/1ps
module testbench;
  import ikr_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [IKR_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, slv, intr_req, global_intr_enable;
  logic [3:0] ext_drv = '0;
  logic [3:0] key_press = '0;
  logic [3:0] ext_pin, key_pin, key_pullup_en, intr_src;
  logic [15:0] lfsr = 16'h9cd6;
  int error_cnt = 0;
  int check_count = 0;

  ikr_pins_model pins_u (.ext_drv(ext_drv), .key_press(key_press), .ext_pin(ext_pin),
    .key_pin(key_pin));
  ikr_top dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_pin(ext_pin), .key_pin(key_pin), .key_pullup_en(key_pullup_en),
    .intr_req(intr_req), .intr_src(intr_src), .global_intr_enable(global_intr_enable));

  // Clock of 50 ns period
  always #25 clk = ~clk;

  // Next pseudo-random word
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic complete_run;
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      complete_run();
    end
    rd = prdata;
    slv = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] exp);
    apb(0, a, 0);
    chk(nm, rd & m, exp);
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    rdc("mask_rst", IKR_MASK_OFS, 32'hff, 32'hff);
    rdc("prio_rst", IKR_PRIO_OFS, 32'hff, 32'hff);
    chk("src_rst", intr_src, 4'hf);
    apb(1, IKR_MASK_OFS, 0);
    rdc("mask_fix", IKR_MASK_OFS, 32'hff, 32'hc0);
    apb(1, IKR_PRIO_OFS, 0);
    rdc("prio_fix", IKR_PRIO_OFS, 32'hff, 32'hc0);
    // Random rising edge enable patterns read back
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      apb(1, IKR_RISE_OFS, {16'h0, lfsr});
      rdc("rise_rw", IKR_RISE_OFS, 32'hf, {28'h0, lfsr[3:0]});
    end
    apb(1, IKR_RISE_OFS, 1);
    apb(1, IKR_FALL_OFS, 0);
    ext_drv[0] <= 1;
    repeat (8) @(posedge clk);
    rdc("edge_flag", IKR_REQ_OFS, 32'h1f, 32'h01);
    chk("req_off", intr_req, 0);
    apb(1, IKR_CTRL_OFS, 1);
    repeat (2) @(posedge clk);
    chk("req_on", intr_req, 1);
    chk("src_sel", intr_src, 0);
    apb(1, IKR_MASK_OFS, 1);
    repeat (2) @(posedge clk);
    chk("req_mask", intr_req, 0);
    apb(1, IKR_MASK_OFS, 0);
    repeat (2) @(posedge clk);
    chk("req_unmask", intr_req, 1);
    // Acknowledge clears the served flag and the global enable
    apb(1, IKR_ACK_OFS, 0);
    rdc("ack_clr", IKR_REQ_OFS, 32'h1f, 0);
    chk("ack_ie", global_intr_enable, 0);
    apb(1, IKR_CTRL_OFS, 1);
    apb(1, IKR_CTRL_OFS, 3);
    // Pin 1 rises while the break runs
    apb(1, IKR_RISE_OFS, 3);
    ext_drv[1] <= 1;
    repeat (8) @(posedge clk);
    chk("brk_ie", global_intr_enable, 0);
    chk("brk_req", intr_req, 0);
    rdc("brk_st", IKR_CTRL_OFS, 32'h2, 32'h2);
    rdc("brk_flag", IKR_REQ_OFS, 32'h1f, 32'h2);
    apb(1, IKR_CTRL_OFS, 0);
    rdc("brk_ret", IKR_CTRL_OFS, 32'h3, 0);
    apb(1, IKR_CLR_OFS, 2);
    // Rise enables cleared, fall enable left set on pin 1
    apb(1, IKR_RISE_OFS, 0);
    apb(1, IKR_FALL_OFS, 2);
    ext_drv <= 4'h0;
    repeat (8) @(posedge clk);
    rdc("spur_edge", IKR_REQ_OFS, 32'h1f, 32'h2);
    // Both enables cleared before port use, so no new flag
    apb(1, IKR_FALL_OFS, 0);
    apb(1, IKR_CLR_OFS, 2);
    ext_drv[1] <= 1;
    repeat (8) @(posedge clk);
    rdc("port_use", IKR_REQ_OFS, 32'h1f, 0);
    // Key mode change with pull-up set first
    apb(1, IKR_PU7_OFS, 1);
    apb(1, IKR_KRM_OFS, 1);
    chk("pullup", key_pullup_en, 4'h1);
    repeat (8) @(posedge clk);
    rdc("krm_flag", IKR_REQ_OFS, 32'h10, 32'h10);
    apb(1, IKR_CLR_OFS, 32'h10);
    key_press[0] <= 1;
    repeat (8) @(posedge clk);
    rdc("key_flag", IKR_REQ_OFS, 32'h10, 32'h10);
    key_press[0] <= 0;
    repeat (8) @(posedge clk);
    apb(1, IKR_CLR_OFS, 32'h10);
    key_press[1] <= 1;
    repeat (8) @(posedge clk);
    rdc("key_idle", IKR_REQ_OFS, 32'h10, 0);
    rdc("key_port", IKR_PORT_OFS, 32'hf, 32'hd);
    apb(0, 8'h2c, 0);
    chk("unmapped_err", {31'h0, slv}, 32'h1);
    chk("unmapped_rd", rd, 32'h0);
    complete_run();
  end
endmodule // testbench

// File: hw/ikr_edge_det.sv
// Purpose: Synchronises pins and detects enabled edges
// Assumes: Pins asynchronous to clk
// Notes: Three-stage sampling, change counted when stages two and three agree
`timescale 1ns/1ps
module ikr_edge_det #(parameter int N = 4) (
  input wire logic clk,
  input wire logic rst,
  ikr_edge_if.det e
);
  logic [N-1:0] s1, s2, s3, stable;
  // Sampling chain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= e.pin;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // Filtered level follows when stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stable <= '0;
    end else begin
      stable <= (s2 & s3) | (stable & (s2 | s3));
    end
  end
  // Edge events; enables left set while the pin is repurposed still fire
  always_comb begin
    e.edge_evt = '0;
    for (int i = 0; i < N; i++) begin
      e.edge_evt[i] = (e.rise_en[i] & s2[i] & s3[i] & ~stable[i]) |
                      (e.fall_en[i] & ~s2[i] & ~s3[i] & stable[i]);
    end
  end
endmodule // ikr_edge_det

// File: hw/ikr_edge_if.sv
// Purpose: Carries edge detector settings and events
// Assumes: Single clock
// Notes: Main module is the control end
`timescale 1ns/1ps
interface ikr_edge_if #(parameter int N = 4);
  logic [N-1:0] rise_en;
  logic [N-1:0] fall_en;
  logic [N-1:0] pin;
  logic [N-1:0] edge_evt;
  modport ctl (output rise_en, output fall_en, output pin, input edge_evt);
  modport det (input rise_en, input fall_en, input pin, output edge_evt);
endinterface

// File: hw/ikr_pkg.sv
// Purpose: Shared constants for the interrupt and key-return controller
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
package ikr_pkg;
  localparam int IKR_AW = 8;
  localparam int IKR_NSRC = 8;
  localparam int IKR_NEXT = 4;
  localparam int IKR_NKEY = 4;
  localparam logic [IKR_AW-1:0] IKR_REQ_OFS = 8'h00;
  localparam logic [IKR_AW-1:0] IKR_MASK_OFS = 8'h04;
  localparam logic [IKR_AW-1:0] IKR_PRIO_OFS = 8'h08;
  localparam logic [IKR_AW-1:0] IKR_RISE_OFS = 8'h0c;
  localparam logic [IKR_AW-1:0] IKR_FALL_OFS = 8'h10;
  localparam logic [IKR_AW-1:0] IKR_KRM_OFS = 8'h14;
  localparam logic [IKR_AW-1:0] IKR_PU7_OFS = 8'h18;
  localparam logic [IKR_AW-1:0] IKR_CTRL_OFS = 8'h1c;
  localparam logic [IKR_AW-1:0] IKR_ACK_OFS = 8'h20;
  localparam logic [IKR_AW-1:0] IKR_CLR_OFS = 8'h24;
  localparam logic [IKR_AW-1:0] IKR_PORT_OFS = 8'h28;
  localparam logic [7:0] IKR_MASK_RST = 8'hff;
  localparam logic [7:0] IKR_PRIO_RST = 8'hff;
  localparam logic [7:0] IKR_FIXED_HI = 8'hc0;
  localparam int IKR_KEY_SRC = 4;
  localparam int IKR_BRK_BIT = 1;
  localparam int IKR_IE_BIT = 0;
  localparam logic [3:0] IKR_NO_SRC = 4'hf;
endpackage

// File: hw/ikr_top.sv
// Purpose: Maskable and software interrupt control with key-return unit
// Assumes: APB slave on clk, pins asynchronous
// Notes: Request bits 0-3 external pins, 4 key, 5 spare, 6-7 fixed
// Functional notes
// - Leftover edge enables may give spurious edge
// - Break acknowledge clears global enable
// - No maskable acknowledge while enable cleared
// - Break holds nothing off except via enable
// - Key mode change may set key flag
// - Unused key lines remain ordinary ports
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module ikr_top
  import ikr_pkg::*;
#(parameter int NEXT = ikr_pkg::IKR_NEXT) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ikr_pkg::IKR_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NEXT-1:0] ext_pin,
  input wire logic [ikr_pkg::IKR_NKEY-1:0] key_pin,
  output logic [ikr_pkg::IKR_NKEY-1:0] key_pullup_en,
  output logic intr_req,
  output logic [3:0] intr_src,
  output logic global_intr_enable
);
  import ikr_pkg::*;
  logic [7:0] intr_request_low_second, intr_mask_low_second, intr_priority_low_second;
  logic [NEXT-1:0] rising_edge_enable_reg, falling_edge_enable_reg;
  logic [IKR_NKEY-1:0] key_return_mode_reg, port7_pullup_reg;
  logic [IKR_NKEY-1:0] k1, k2, k3, key_lvl, key_lvl_q;
  logic in_break;
  logic wr, rd, krm_chg, key_evt, ack_wr, clr_wr;
  logic [3:0] next_src;
  logic [7:0] set_bits, clr_bits, eligible;
  ikr_edge_if #(.N(NEXT)) eif ();

  ikr_edge_det #(.N(NEXT)) u_det (.clk(clk), .rst(rst), .e(eif));
  assign eif.rise_en = rising_edge_enable_reg;
  assign eif.fall_en = falling_edge_enable_reg;
  assign eif.pin = ext_pin;

  // Bus strobes, one-cycle access
  assign wr = psel & penable & pwrite & pready;
  assign rd = psel & ~penable & ~pwrite;
  assign ack_wr = wr && paddr == IKR_ACK_OFS;
  assign clr_wr = wr && paddr == IKR_CLR_OFS;
  assign krm_chg = wr && paddr == IKR_KRM_OFS && pwdata[IKR_NKEY-1:0] != key_return_mode_reg;

  // Priority pick among eligible requests
  function automatic logic [3:0] pick(input logic [7:0] el, input logic [7:0] pr);
    logic [3:0] r;
    r = IKR_NO_SRC;
    for (int i = 7; i >= 0; i--) begin
      if (el[i] && pr[i]) r = 4'(i);
    end
    if (r == IKR_NO_SRC) begin
      for (int i = 7; i >= 0; i--) begin
        if (el[i]) r = 4'(i);
      end
    end
    return r;
  endfunction

  // Pending, unmasked and globally enabled requests only
  assign eligible = intr_request_low_second & ~intr_mask_low_second &
                    {8{global_intr_enable}};
  assign next_src = pick(eligible, ~intr_priority_low_second);

  // Key synchronisers and active-low level on enabled lines only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      k1 <= '1;
      k2 <= '1;
      k3 <= '1;
      key_lvl <= '0;
      key_lvl_q <= '0;
    end else begin
      k1 <= key_pin;
      k2 <= k1;
      k3 <= k2;
      key_lvl <= (~k2 & ~k3 & key_return_mode_reg) |
                 (key_lvl & ~(k2 & k3) & key_return_mode_reg);
      key_lvl_q <= key_lvl;
    end
  end
  assign key_evt = |(key_lvl & ~key_lvl_q) | krm_chg;

  // Request flag set and clear; set wins
  always_comb begin
    set_bits = '0;
    set_bits[NEXT-1:0] = eif.edge_evt;
    set_bits[IKR_KEY_SRC] = key_evt;
    clr_bits = '0;
    if (clr_wr) clr_bits = pwdata[7:0];
    if (wr && paddr == IKR_REQ_OFS) clr_bits = ~pwdata[7:0];
    if (ack_wr && intr_src != IKR_NO_SRC) clr_bits[intr_src[2:0]] = 1'b1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      intr_request_low_second <= '0;
    end else begin
      intr_request_low_second <= ((intr_request_low_second & ~clr_bits) | set_bits) &
                                 ~IKR_FIXED_HI;
    end
  end

  // Configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      intr_mask_low_second <= IKR_MASK_RST;
      intr_priority_low_second <= IKR_PRIO_RST;
      rising_edge_enable_reg <= '0;
      falling_edge_enable_reg <= '0;
      key_return_mode_reg <= '0;
      port7_pullup_reg <= '0;
    end else if (wr) begin
      case (paddr)
        IKR_MASK_OFS: intr_mask_low_second <= pwdata[7:0] | IKR_FIXED_HI;
        IKR_PRIO_OFS: intr_priority_low_second <= pwdata[7:0] | IKR_FIXED_HI;
        IKR_RISE_OFS: rising_edge_enable_reg <= pwdata[NEXT-1:0];
        IKR_FALL_OFS: falling_edge_enable_reg <= pwdata[NEXT-1:0];
        IKR_KRM_OFS: key_return_mode_reg <= pwdata[IKR_NKEY-1:0];
        IKR_PU7_OFS: port7_pullup_reg <= pwdata[IKR_NKEY-1:0];
        default: ;
      endcase
    end
  end

  // Global enable and break; break acknowledge clears enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      global_intr_enable <= 1'b0;
      in_break <= 1'b0;
    end else if (wr && paddr == IKR_CTRL_OFS) begin
      if (pwdata[IKR_BRK_BIT]) begin
        global_intr_enable <= 1'b0;
        in_break <= 1'b1;
      end else begin
        global_intr_enable <= pwdata[IKR_IE_BIT];
        in_break <= 1'b0;
      end
    end else if (ack_wr && intr_src != IKR_NO_SRC) begin
      global_intr_enable <= 1'b0;
    end
  end

  // Registered interrupt outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      intr_req <= 1'b0;
      intr_src <= IKR_NO_SRC;
      key_pullup_en <= '0;
    end else begin
      intr_req <= next_src != IKR_NO_SRC;
      intr_src <= next_src;
      key_pullup_en <= port7_pullup_reg;
    end
  end

  // APB read data and ready
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable && paddr > IKR_PORT_OFS;
      if (rd) begin
        case (paddr)
          IKR_REQ_OFS: prdata <= {24'h0, intr_request_low_second};
          IKR_MASK_OFS: prdata <= {24'h0, intr_mask_low_second};
          IKR_PRIO_OFS: prdata <= {24'h0, intr_priority_low_second};
          IKR_RISE_OFS: prdata <= 32'(rising_edge_enable_reg);
          IKR_FALL_OFS: prdata <= 32'(falling_edge_enable_reg);
          IKR_KRM_OFS: prdata <= 32'(key_return_mode_reg);
          IKR_PU7_OFS: prdata <= 32'(port7_pullup_reg);
          IKR_CTRL_OFS: prdata <= {30'h0, in_break, global_intr_enable};
          IKR_ACK_OFS: prdata <= {28'h0, intr_src};
          IKR_PORT_OFS: prdata <= {28'h0, k3};
          default: prdata <= '0;
        endcase
      end
    end
  end

  // Checks
  // Request output lags the mask by one cycle, so compare with the mask it was built from
  maskd_never_a: assert property (@(posedge clk) disable iff (rst)
    intr_req |-> (($past(intr_mask_low_second) >> intr_src[2:0]) & 8'h01) == 8'h00)
    else $error("masked served");
  brk_clears_ie_a: assert property (@(posedge clk) disable iff (rst)
    (wr && paddr == IKR_CTRL_OFS && pwdata[IKR_BRK_BIT]) |=> !global_intr_enable)
    else $error("break kept enable");
  no_ack_ie_a: assert property (@(posedge clk) disable iff (rst)
    !global_intr_enable |=> !intr_req) else $error("request without enable");
  brk_hold_a: assert property (@(posedge clk) disable iff (rst)
    (in_break && !global_intr_enable && !wr) |=> !global_intr_enable)
    else $error("break enable rose");
  krm_sets_a: assert property (@(posedge clk) disable iff (rst)
    krm_chg |=> intr_request_low_second[IKR_KEY_SRC]) else $error("mode change no flag");
  key_unused_a: assert property (@(posedge clk) disable iff (rst)
    (key_return_mode_reg == '0) |=> (key_lvl == '0)) else $error("unused key fired");
  key_low_a: assert property (@(posedge clk) disable iff (rst)
    (key_lvl[0] && !key_lvl_q[0]) |=> intr_request_low_second[IKR_KEY_SRC])
    else $error("key low no flag");
  fixed_hi_a: assert property (@(posedge clk) disable iff (rst)
    intr_mask_low_second[7:6] == 2'b11 && intr_request_low_second[7:6] == 2'b00)
    else $error("fixed bits lost");
  edge_flag_a: assert property (@(posedge clk) disable iff (rst)
    eif.edge_evt[0] |=> intr_request_low_second[0]) else $error("edge lost");
  cov_req_c: cover property (@(posedge clk) intr_req ##1 ack_wr);
  cov_brk_c: cover property (@(posedge clk) in_break && intr_request_low_second != '0);
  cov_key_c: cover property (@(posedge clk) krm_chg);
endmodule // ikr_top
